// [bench/bus_control_port_pin_mux_test.sv]
// self-checking bench for the bus control port pin mux
// assumes: package compiled first, partner model beside it, one 10 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "bus_control_port_cfg.svh"
module bus_control_port_pin_mux_test
    import bus_control_port_pkg::*;
;
    localparam logic [31:0] rel = 32'h1 << `CFG_RELEASE_EN;
    localparam logic [31:0] bus_request_out = 32'h1 << `CFG_BUS_REQUEST_OUT_EN;
    localparam logic [31:0] lower_column_strobe = (32'h1 << `CFG_LOWER_COLUMN_STROBE_SEL) | 32'h1 | bus_request_out;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic manual_resetn = 1'b1;
    logic hw_standby = 1'b0;
    logic sw_standby = 1'b0;
    logic [2:0] mode = 3'h1;
    bus_ctl_t bus_ctl = 10'h392; // cs0, lwr, lower_column_strobe, grant, column low
    pin_vec_t ext = 9'h010;
    pin_vec_t level, pin_out, pin_oe;
    logic wait_n, bus_request_in_in_n, awready, wready, bvalid, arready, rvalid;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [17:0] awaddr = 18'h0, araddr = 18'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    int mismatches = 0;
    int check_count = 0;

    // clock
    always #50 ref_clk = ~ref_clk;

    bus_control_port_pin_mux dut (.i_ref_clk(ref_clk), .i_resetn(resetn),
        .i_manual_resetn(manual_resetn), .i_hw_standby(hw_standby),
        .i_sw_standby(sw_standby), .i_mode(mode), .i_bus_ctl(bus_ctl), .o_wait_n(wait_n),
        .o_bus_request_in_n(bus_request_in_in_n), .i_pin(level), .o_pin(pin_out), .o_pin_oe(pin_oe),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
        .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf), .o_bvalid(bvalid),
        .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
        .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata),
        .o_rresp(rresp));
    bus_pin_partner far_side (.i_drive(pin_out), .i_drive_oe(pin_oe), .i_ext(ext),
        .o_level(level));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ready is sampled at the falling edge; inputs only move after rising edges
    task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
        logic a, w, b;
        logic [1:0] r;
        a = 1'b0;
        w = 1'b0;
        @(posedge ref_clk);
        awaddr <= {idx, 2'b00};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge ref_clk);
            a = a | (awvalid & awready);
            w = w | (wvalid & wready);
            @(posedge ref_clk);
            if (a === 1'b1) awvalid <= 1'b0;
            if (w === 1'b1) wvalid <= 1'b0;
        end while (!(a === 1'b1 && w === 1'b1));
        do begin
            @(negedge ref_clk);
            b = bvalid;
            r = bresp;
            @(posedge ref_clk);
        end while (b !== 1'b1);
        bready <= 1'b0;
        chk(32'(r), 32'(er), "write response");
    endtask

    // data compared only when the access is expected to succeed
    task automatic rd(input logic [15:0] idx, input logic [31:0] ed, input logic [1:0] er);
        logic h;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge ref_clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge ref_clk);
            h = arready;
            @(posedge ref_clk);
        end while (h !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(negedge ref_clk);
            h = rvalid;
            d = rdata;
            r = rresp;
            @(posedge ref_clk);
        end while (h !== 1'b1);
        rready <= 1'b0;
        chk(32'(r), 32'(er), "read response");
        if (er === `RESP_OKAY) chk(d, ed, "read data");
    endtask

    // long enough for mode and pin synchronisers plus the output flop
    task automatic check_pins(input logic [8:0] v, input logic [8:0] oe);
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk);
        chk(32'(pin_oe), 32'(oe), "pin enables");
        chk(32'(pin_out & oe), 32'(v & oe), "pin values");
    endtask

    task automatic set_mode(input logic [2:0] m);
        @(posedge ref_clk);
        mode <= m;
    endtask

    task automatic after_reset();
        check_pins(9'h000, {4'h8, 5'b10000});
        rd(`IDX_G_OUTPUT_DATA, 32'h0, `RESP_OKAY);
        rd(`IDX_G_DIRECTION, 32'h0, `RESP_OKAY);
    endtask

    task automatic gpio_readback();
        wr(`IDX_G_DIRECTION, 32'h0000000f, `RESP_OKAY);
        wr(`IDX_G_OUTPUT_DATA, 32'h00000005, `RESP_OKAY);
        check_pins({4'h0, 5'b00101}, {4'h8, 5'b01111});
        rd(`IDX_G_PIN_STATE, 32'h00000015, `RESP_OKAY);
        wr(`IDX_G_PIN_STATE, 32'h000000ff, `RESP_OKAY);
        rd(`IDX_G_OUTPUT_DATA, 32'h00000005, `RESP_OKAY);
    endtask

    task automatic unmapped_access();
        wr(16'h1234, 32'h0, `RESP_SLVERR);
        rd(16'h1234, 32'h0, `RESP_SLVERR);
    endtask

    task automatic port_g_bus_mode();
        set_mode(3'h4);
        wr(`IDX_G_DIRECTION, 32'h0000001e, `RESP_OKAY);
        wr(`IDX_G_OUTPUT_DATA, 32'h00000001, `RESP_OKAY);
        check_pins({4'h0, 5'b01110}, {4'h8, 5'b11110});
        wr(`IDX_BUS_CONFIG, 32'h1 << `CFG_DRAM, `RESP_OKAY);
        check_pins({4'h0, 5'b01110}, {4'h8, 5'b11111});
        wr(`IDX_BUS_CONFIG, 32'h1 << `CFG_PSRAM, `RESP_OKAY);
        check_pins({4'h0, 5'b01111}, {4'h8, 5'b11111});
        set_mode(3'h3);
        check_pins(9'h000, {4'h0, 5'b11110});
    endtask

    task automatic port_f_functions();
        wr(`IDX_BUS_CONFIG, rel, `RESP_OKAY);
        wr(`IDX_F_DIRECTION, 32'h0000000f, `RESP_OKAY);
        wr(`IDX_F_OUTPUT_DATA, 32'h00000009, `RESP_OKAY);
        check_pins({4'h9, 5'b00000}, {4'hf, 5'b11110});
        wr(`IDX_F_DIRECTION, 32'h0, `RESP_OKAY);
        set_mode(3'h4);
        check_pins({4'h0, 5'b01110}, {4'ha, 5'b11110});
        chk(32'(bus_request_in_in_n), 32'h0, "bus request in");
        wr(`IDX_BUS_CONFIG, bus_request_out, `RESP_OKAY);
        check_pins({4'h4, 5'b01110}, {4'hc, 5'b11110});
        wr(`IDX_BUS_CONFIG, 32'h1 << `CFG_WAIT_EN, `RESP_OKAY);
        check_pins({4'h0, 5'b01110}, {4'h8, 5'b11110});
        chk(32'(wait_n), 32'h0, "wait in");
        wr(`IDX_BUS_CONFIG, lower_column_strobe, `RESP_OKAY);
        check_pins({4'h0, 5'b01110}, {4'hc, 5'b11110});
        wr(`IDX_BUS_CONFIG, lower_column_strobe | (32'h1 << `CFG_BUS_WIDTH), `RESP_OKAY);
        check_pins({4'h4, 5'b01110}, {4'hc, 5'b11110});
    endtask

    // strobes move during standby so holding and following differ
    task automatic standby_hold();
        wr(`IDX_BUS_CONFIG, rel, `RESP_OKAY);
        @(posedge ref_clk);
        sw_standby <= 1'b1;
        check_pins(9'h000, 9'h000);
        @(posedge ref_clk);
        sw_standby <= 1'b0;
        wr(`IDX_BUS_CONFIG, rel | (32'h1 << `CFG_HOLD), `RESP_OKAY);
        check_pins({4'h0, 5'b01110}, {4'ha, 5'b11110});
        @(posedge ref_clk);
        sw_standby <= 1'b1;
        repeat (3) @(posedge ref_clk);
        bus_ctl.bus_grant_n <= 1'b1;
        bus_ctl.chip_select_n <= 4'h0;
        check_pins({4'h0, 5'b01110}, {4'ha, 5'b11110});
        @(posedge ref_clk);
        sw_standby <= 1'b0;
    endtask

    task automatic reset_retention();
        @(posedge ref_clk);
        manual_resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        manual_resetn <= 1'b1;
        check_pins(9'h000, {4'h8, 5'b11110});
        rd(`IDX_G_OUTPUT_DATA, 32'h00000001, `RESP_OKAY);
        @(posedge ref_clk);
        hw_standby <= 1'b1;
        repeat (3) @(posedge ref_clk);
        hw_standby <= 1'b0;
        check_pins(9'h000, {4'h8, 5'b10000});
        rd(`IDX_G_OUTPUT_DATA, 32'h0, `RESP_OKAY);
        // narrow default: mode must reach the synchroniser before the reload
        set_mode(3'h2);
        repeat (3) @(posedge ref_clk);
        hw_standby <= 1'b1;
        repeat (3) @(posedge ref_clk);
        hw_standby <= 1'b0;
        check_pins(9'h000, {4'h8, 5'b00000});
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        after_reset();
        gpio_readback();
        unmapped_access();
        port_g_bus_mode();
        port_f_functions();
        standby_hold();
        reset_retention();
        print_verdict();
    end

    // watchdog, far beyond the roughly 230 cycles the sequence needs
    initial begin
        #(20000 * 100);
        mismatches++;
        print_verdict();
    end
endmodule
`default_nettype wire

// [bench/bus_pin_partner.sv]
// outside parties on the port pins: memories, bus masters, pull resistors
// assumes: bench sets the level each outside party puts on an undriven pin
`timescale 1ns/1ps
`default_nettype none
module bus_pin_partner
    import bus_control_port_pkg::*;
(
    input wire pin_vec_t i_drive,
    input wire pin_vec_t i_drive_oe,
    input wire pin_vec_t i_ext,
    output pin_vec_t o_level
);
    // wire level: block wins where it drives, outside party elsewhere
    always_comb begin
        o_level = (i_drive & i_drive_oe) | (i_ext & ~i_drive_oe);
    end
endmodule
`default_nettype wire

// [src/bus_control_port_cfg.svh]
// offsets, field positions, reset values for the bus control port pin mux
// assumes: included by bare name from the package and the design file
`ifndef BUS_CONTROL_PORT_CFG_SVH
`define BUS_CONTROL_PORT_CFG_SVH
// register indexes; byte address is four times the index
`define IDX_G_DIRECTION 16'hfebf
`define IDX_G_OUTPUT_DATA 16'hff6f
`define IDX_G_PIN_STATE 16'hff5f
`define IDX_F_DIRECTION 16'hfebe
`define IDX_F_OUTPUT_DATA 16'hff6e
`define IDX_BUS_CONFIG 16'hfe00
`define ADDR_W 18
// reset values
`define G_DIR_RST_WIDE 8'hf0
`define G_DIR_RST_NARROW 8'he0
`define G_DATA_RST 8'h00
`define F_RST 4'h0
// bus config field positions
`define CFG_MTS_LSB 0
`define CFG_BUS_WIDTH 3
`define CFG_LOWER_COLUMN_STROBE_SEL 4
`define CFG_BUS_REQUEST_OUT_EN 5
`define CFG_WAIT_EN 6
`define CFG_RELEASE_EN 7
`define CFG_HOLD 8
`define CFG_DRAM 9
`define CFG_PSRAM 10
`define CFG_W 11
// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// [src/bus_control_port_pin_mux.sv]
// pin function selection and general i/o for port g and port f pins 3..0
// assumes: one 10 MHz clock, axi4-lite master on the same clock,
// bus controller strobes and standby levels synchronous to that clock
`timescale 1ns/1ps
`default_nettype none
`include "bus_control_port_cfg.svh"
module bus_control_port_pin_mux
    import bus_control_port_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_manual_resetn,
    input wire logic i_hw_standby,
    input wire logic i_sw_standby,
    input wire logic [2:0] i_mode,
    input wire bus_ctl_t i_bus_ctl,
    output logic o_wait_n,
    output logic o_bus_request_in_n,
    input wire pin_vec_t i_pin,
    output pin_vec_t o_pin,
    output pin_vec_t o_pin_oe,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [`ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [`ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp
);
    // pin and strap synchronisers; first stage read only by second
    pin_vec_t pin_meta_ff, pin_sync_ff;
    logic [2:0] mode_meta_ff, mode_sync_ff;
    always_ff @(posedge i_ref_clk) begin
        pin_meta_ff <= i_pin;
        pin_sync_ff <= pin_meta_ff;
        mode_meta_ff <= i_mode;
        mode_sync_ff <= mode_meta_ff;
    end

    // mode classes
    logic bus_mode, exp_mode, small_mode, single_mode;
    assign exp_mode = (mode_sync_ff >= 3'h4) && (mode_sync_ff <= 3'h6);
    assign small_mode = (mode_sync_ff == 3'h1) || (mode_sync_ff == 3'h2);
    assign bus_mode = exp_mode || small_mode;
    assign single_mode = !bus_mode;

    // register state
    logic [4:0] g_dir_ff, g_data_ff;
    logic [3:0] f_dir_ff, f_data_ff;
    bus_cfg_t cfg_ff;
    logic [7:0] g_dir_rst;
    logic por;
    assign por = !i_resetn || i_hw_standby;
    // wide default only in modes 1, 4 and 5
    assign g_dir_rst = (mode_sync_ff == 3'h1 || mode_sync_ff == 3'h4 || mode_sync_ff == 3'h5) ?
        `G_DIR_RST_WIDE : `G_DIR_RST_NARROW;

    // axi write and read decode; write address and data are taken together
    logic wr_go, rd_go;
    logic [15:0] wr_idx, rd_idx;
    logic wr_hit, rd_hit;
    assign wr_go = i_awvalid && i_wvalid && !o_bvalid;
    assign rd_go = i_arvalid && !o_rvalid;
    assign o_awready = wr_go;
    assign o_wready = wr_go;
    assign o_arready = !o_rvalid;
    assign wr_idx = i_awaddr[17:2];
    assign rd_idx = i_araddr[17:2];
    assign wr_hit = (wr_idx == `IDX_G_DIRECTION) || (wr_idx == `IDX_G_OUTPUT_DATA) ||
        (wr_idx == `IDX_G_PIN_STATE) || (wr_idx == `IDX_F_DIRECTION) ||
        (wr_idx == `IDX_F_OUTPUT_DATA) || (wr_idx == `IDX_BUS_CONFIG);
    assign rd_hit = (rd_idx == `IDX_G_DIRECTION) || (rd_idx == `IDX_G_OUTPUT_DATA) ||
        (rd_idx == `IDX_G_PIN_STATE) || (rd_idx == `IDX_F_DIRECTION) ||
        (rd_idx == `IDX_F_OUTPUT_DATA) || (rd_idx == `IDX_BUS_CONFIG);
    logic wr_b0, wr_b1;
    assign wr_b0 = wr_go && i_wstrb[0];
    assign wr_b1 = wr_go && i_wstrb[1];

    // port g direction: only power-on or hardware standby reload it
    always_ff @(posedge i_ref_clk) begin
        if (por) begin
            g_dir_ff <= g_dir_rst[4:0];
        end else if (wr_b0 && wr_idx == `IDX_G_DIRECTION) begin
            g_dir_ff <= i_wdata[4:0];
        end
    end

    // port g output data; the pin state index is not writable
    always_ff @(posedge i_ref_clk) begin
        if (por) begin
            g_data_ff <= 5'(`G_DATA_RST);
        end else if (wr_b0 && wr_idx == `IDX_G_OUTPUT_DATA) begin
            g_data_ff <= i_wdata[4:0];
        end
    end

    // port f low pins direction and data
    always_ff @(posedge i_ref_clk) begin
        if (por) begin
            f_dir_ff <= `F_RST;
            f_data_ff <= `F_RST;
        end else begin
            if (wr_b0 && wr_idx == `IDX_F_DIRECTION) begin
                f_dir_ff <= i_wdata[3:0];
            end
            if (wr_b0 && wr_idx == `IDX_F_OUTPUT_DATA) begin
                f_data_ff <= i_wdata[3:0];
            end
        end
    end

    // bus configuration; a manual reset also clears it
    always_ff @(posedge i_ref_clk) begin
        if (por || !i_manual_resetn) begin
            cfg_ff <= '0;
        end else if (wr_idx == `IDX_BUS_CONFIG) begin
            if (wr_b0) begin
                cfg_ff[7:0] <= i_wdata[7:0];
            end
            if (wr_b1) begin
                cfg_ff[`CFG_W-1:8] <= i_wdata[`CFG_W-1:8];
            end
        end
    end

    // write response
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_bvalid <= 1'b0;
            o_bresp <= `RESP_OKAY;
        end else if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // read data mux; port g direction reads back zero since its value is undefined
    logic [31:0] nxt_rdata;
    pin_vec_t readback;
    always_comb begin
        readback.f = (f_dir_ff & f_data_ff) | (~f_dir_ff & pin_sync_ff.f);
        readback.g = (g_dir_ff & g_data_ff) | (~g_dir_ff & pin_sync_ff.g);
        case (rd_idx)
            `IDX_G_DIRECTION: nxt_rdata = 32'h0000_0000;
            `IDX_G_OUTPUT_DATA: nxt_rdata = {27'h0, g_data_ff};
            `IDX_G_PIN_STATE: nxt_rdata = {27'h0, readback.g};
            `IDX_F_DIRECTION: nxt_rdata = {28'h0, f_dir_ff};
            `IDX_F_OUTPUT_DATA: nxt_rdata = {28'h0, f_data_ff};
            `IDX_BUS_CONFIG: nxt_rdata = {21'h0, cfg_ff};
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    // read response
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= `RESP_OKAY;
        end else if (rd_go) begin
            o_rvalid <= 1'b1;
            o_rdata <= nxt_rdata;
            o_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    // function selection per pin
    logic lower_column_strobe_ok;
    pin_vec_t fn_bus, fn_out, fn_oe;
    assign lower_column_strobe_ok = exp_mode && cfg_ff.lower_column_strobe_select && !cfg_ff.bus_width_select &&
        (cfg_ff.memory_type_select >= 3'h1) && (cfg_ff.memory_type_select <= 3'h3);
    always_comb begin
        // general i/o by default: data bit driven where direction bit is set
        fn_out.f = f_data_ff;
        fn_oe.f = f_dir_ff;
        fn_out.g = g_data_ff;
        fn_oe.g = g_dir_ff;
        fn_bus = '0;
        // F3: strobe regardless of its direction bit
        if (bus_mode) begin
            fn_out.f[3] = i_bus_ctl.low_byte_write_strobe_n;
            fn_oe.f[3] = 1'b1;
            fn_bus.f[3] = 1'b1;
        end
        // F2: column strobe, then bus request out, then wait input
        if (lower_column_strobe_ok) begin
            fn_out.f[2] = i_bus_ctl.lower_column_strobe_n;
            fn_oe.f[2] = 1'b1;
            fn_bus.f[2] = 1'b1;
        end else if (bus_mode && cfg_ff.bus_request_out_enable) begin
            fn_out.f[2] = i_bus_ctl.bus_request_out_n;
            fn_oe.f[2] = 1'b1;
            fn_bus.f[2] = 1'b1;
        end else if (bus_mode && cfg_ff.wait_pin_enable) begin
            fn_oe.f[2] = 1'b0;
        end
        // F1 and F0: bus release pair
        if (bus_mode && cfg_ff.bus_release_enable) begin
            fn_out.f[1] = i_bus_ctl.bus_grant_n;
            fn_oe.f[1] = 1'b1;
            fn_bus.f[1] = 1'b1;
            fn_oe.f[0] = 1'b0;
        end
        // G4: chip select 0 in every bus mode where its direction bit is set
        if (bus_mode && g_dir_ff[4]) begin
            fn_out.g[4] = i_bus_ctl.chip_select_n[0];
            fn_bus.g[4] = 1'b1;
        end
        // G3..G1: chip selects 1..3 only in the expanded modes
        for (int i = 1; i < 4; i++) begin
            if (exp_mode && g_dir_ff[4-i]) begin
                fn_out.g[4-i] = i_bus_ctl.chip_select_n[i];
                fn_bus.g[4-i] = 1'b1;
            end
        end
        // G0: dram wins if software sets both interface bits
        if (exp_mode && cfg_ff.dram_select) begin
            fn_out.g[0] = i_bus_ctl.column_strobe_n;
            fn_oe.g[0] = 1'b1;
            fn_bus.g[0] = 1'b1;
        end else if (exp_mode && cfg_ff.psram_select) begin
            fn_out.g[0] = i_bus_ctl.output_enable_n;
            fn_oe.g[0] = 1'b1;
            fn_bus.g[0] = 1'b1;
        end
    end

    // software standby: bus pins freeze or float, general pins unaffected
    pin_vec_t nxt_pin, nxt_oe;
    always_comb begin
        nxt_pin = fn_out;
        nxt_oe = fn_oe;
        if (i_sw_standby) begin
            nxt_pin = (fn_bus & o_pin) | (~fn_bus & fn_out);
            nxt_oe = (fn_bus & (o_pin_oe & {9{cfg_ff.standby_output_hold}})) | (~fn_bus & fn_oe);
        end
    end

    // pin drivers registered so no glitch reaches the board
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_pin <= '1;
            o_pin_oe <= '0;
        end else begin
            o_pin <= nxt_pin;
            o_pin_oe <= nxt_oe;
        end
    end

    // sensed strobes back to the bus controller, idle high when not selected
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_wait_n <= 1'b1;
            o_bus_request_in_n <= 1'b1;
        end else begin
            o_wait_n <= (bus_mode && !lower_column_strobe_ok && !cfg_ff.bus_request_out_enable &&
                cfg_ff.wait_pin_enable) ? pin_sync_ff.f[2] : 1'b1;
            o_bus_request_in_n <= (bus_mode && cfg_ff.bus_release_enable) ?
                pin_sync_ff.f[0] : 1'b1;
        end
    end

    // checks; sampled reset in the antecedent skips the edge that releases reset,
    // where disable iff already sees reset gone but the pin flops still hold reset values
    a_lwr_follow: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        i_resetn && bus_mode && !i_sw_standby
        |=> o_pin_oe.f[3] && o_pin.f[3] == $past(i_bus_ctl.low_byte_write_strobe_n))
        else $error("low write strobe not driven");
    a_lower_column_strobe_gate: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        i_resetn && (!exp_mode || cfg_ff.bus_width_select || cfg_ff.memory_type_select == 3'h0 ||
        cfg_ff.memory_type_select > 3'h3) && !cfg_ff.bus_request_out_enable && !f_dir_ff[2]
        |=> !o_pin_oe.f[2])
        else $error("lower column strobe selected outside its conditions");
    a_f2_priority: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        i_resetn && bus_mode && !lower_column_strobe_ok && cfg_ff.bus_request_out_enable && !i_sw_standby
        |=> o_pin_oe.f[2] && o_pin.f[2] == $past(i_bus_ctl.bus_request_out_n))
        else $error("bus request out not on f2");
    a_grant_out: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        i_resetn && bus_mode && cfg_ff.bus_release_enable && !i_sw_standby |=> o_pin_oe.f[1])
        else $error("bus grant not driven");
    a_request_in: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        bus_mode && cfg_ff.bus_release_enable |=> !o_pin_oe.f[0])
        else $error("bus request input driven");
    a_dir_reset: assert property (@(posedge i_ref_clk)
        i_hw_standby |=> g_dir_ff == $past(g_dir_rst[4:0]))
        else $error("direction not reloaded");
    a_dir_keep: assert property (@(posedge i_ref_clk) disable iff (por)
        !(wr_b0 && wr_idx == `IDX_G_DIRECTION) |=> $stable(g_dir_ff))
        else $error("direction changed without write");
    a_standby_float: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        i_sw_standby && !cfg_ff.standby_output_hold && fn_bus.g[4] |=> !o_pin_oe.g[4])
        else $error("bus pin not floated in standby");
    a_single_gp: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        i_resetn && single_mode
        |=> o_pin_oe.g == $past(g_dir_ff) && o_pin.g == $past(g_data_ff))
        else $error("port g not general in single chip mode");
    a_cs_exp: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        i_resetn && exp_mode && g_dir_ff[2] && !i_sw_standby
        |=> o_pin_oe.g[2] && o_pin.g[2] == $past(i_bus_ctl.chip_select_n[2]))
        else $error("chip select 2 not driven");
    a_pin_read: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
        rd_go && rd_idx == `IDX_G_PIN_STATE
        |=> o_rvalid && o_rdata[4:0] == $past(readback.g) && o_rdata[31:5] == 27'h0)
        else $error("pin state readback wrong");
    a_data_write: assert property (@(posedge i_ref_clk) disable iff (por)
        wr_b0 && wr_idx == `IDX_G_PIN_STATE |=> $stable(g_data_ff))
        else $error("pin state write reached data register");
    c_lower_column_strobe: cover property (@(posedge i_ref_clk) lower_column_strobe_ok && o_pin_oe.f[2]);
    c_hold: cover property (@(posedge i_ref_clk) i_sw_standby && cfg_ff.standby_output_hold
        && fn_bus.f[3]);
    c_psram: cover property (@(posedge i_ref_clk) exp_mode && cfg_ff.psram_select
        && o_pin_oe.g[0]);
    c_bad_addr: cover property (@(posedge i_ref_clk) o_bvalid && o_bresp == `RESP_SLVERR);
endmodule
`default_nettype wire

// [src/bus_control_port_pkg.sv]
// types shared by the bus control port pin mux
// assumes: cfg header reachable on the include path
`include "bus_control_port_cfg.svh"
package bus_control_port_pkg;
    // strobes coming from the bus controller, all active low
    typedef struct packed {
        logic [3:0] chip_select_n;
        logic column_strobe_n;
        logic output_enable_n;
        logic low_byte_write_strobe_n;
        logic lower_column_strobe_n;
        logic bus_request_out_n;
        logic bus_grant_n;
    } bus_ctl_t;
    // software bus configuration
    typedef struct packed {
        logic psram_select;
        logic dram_select;
        logic standby_output_hold;
        logic bus_release_enable;
        logic wait_pin_enable;
        logic bus_request_out_enable;
        logic lower_column_strobe_select;
        logic bus_width_select;
        logic [2:0] memory_type_select;
    } bus_cfg_t;
    // pin group: level, drive value, drive enable
    typedef struct packed {
        logic [3:0] f;
        logic [4:0] g;
    } pin_vec_t;
endpackage
